// file: logic/csisb_pkg.sv
/*
   Constants and carrier types for the single-byte three-wire serial block.
   Assumes one system clock domain; the serial pins arrive asynchronously.
*/
// What this block does
// - With the port on and auto transfer off, a shift register write starts one byte exchange.
// - Each bit leaves on a serial clock fall; the input bit is sampled on the next rise.
// - Send and receive run together: the old byte shifts out while new bits shift in.
// - Each finished byte exchange raises the transfer done interrupt.
// - The auto transfer mode bit has no effect in single-byte mode.
// - Writing the shift register forces the serial data output low before the first bit.
`default_nettype none

package csisb_pkg;
   // ==========================================================
   // Sizes and reset values
   localparam int unsigned BYTE_BITS    = 8;
   localparam logic [2:0]  LAST_BIT     = 3'h7;
   localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
   localparam logic [7:0]  SHIFT_RST    = 8'h00;
   localparam logic        SDO_RST      = 1'h1;
   localparam logic        SCK_IDLE     = 1'h1;
   localparam logic        FLAG_RST     = 1'h0;
   localparam logic [1:0]  PIN_SYNC_RST = 2'h3;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } csisb_wr_t;

   typedef struct packed {
      logic port_enable_bit;
      logic auto_transfer_enable_bit;
      logic auto_transfer_mode_bit;
   } csisb_mode_t;
endpackage

`default_nettype wire

// file: logic/csisb_sync.sv
/*
   Three-stage synchroniser with agreement filter for asynchronous pins.
   Assumes inputs change slower than a few system clocks.
*/
`default_nettype none

module csisb_sync #(
   parameter int unsigned     WIDTH = 2,
   parameter logic [WIDTH-1:0] RST  = '0
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] ff1;
   logic [WIDTH-1:0] ff2;
   logic [WIDTH-1:0] ff3;

   // ==========================================================
   // Chain; ff1 feeds only ff2
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ff1 <= RST;
         ff2 <= RST;
         ff3 <= RST;
      end else begin
         ff1 <= async_in;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // ==========================================================
   // A change counts once stages two and three agree
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         level <= RST;
      end else begin
         for (int i = 0; i < int'(WIDTH); i++) begin
            if (ff2[i] == ff3[i]) begin
               level[i] <= ff3[i];
            end
         end
      end
   end
endmodule

`default_nettype wire

// file: logic/csisb_top.sv
/*
   Single-byte exchange engine of a three-wire clocked serial port, slave clocked,
   with its checks next to the logic they guard.
   Assumes the peer drives an idle-high serial clock far slower than clock, holds
   each clock level for at least four system clocks, and changes its data only
   with the falling edge. Software keeps writes apart by watching the busy flag.
*/
`default_nettype none

module csisb_top (
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire csisb_pkg::csisb_mode_t mode,
   input  wire csisb_pkg::csisb_wr_t   shift_write,
   input  wire logic                   serial_clock_pin,
   input  wire logic                   serial_data_in_pin,
   output logic                        serial_data_out_pin,
   output logic [7:0]                  serial_shift_register,
   output logic                        transfer_busy_flag,
   output logic                        transfer_done_irq
);
   logic [1:0] pins_level;
   logic       sck_level;
   logic       sck_prev;
   logic       sck_fall;
   logic       sck_rise;
   logic       sin_level;
   logic       have_fall;
   logic [2:0] bit_cnt;
   logic       wr_ok;
   logic       drive_bit;
   logic       last_rise;
   logic       sample;

   // ==========================================================
   // Edge decode, shared by both serial clock edges
   // One helper for both edges keeps fall and rise decoding from drifting apart
   function automatic logic edge_seen(
      input logic was,
      input logic now,
      input logic rising
   );
      return (was != now) && (now == rising);
   endfunction

   csisb_sync #(
      .WIDTH (2),
      .RST   (csisb_pkg::PIN_SYNC_RST)
   ) u_sync (
      .clock    (clock),
      .nrst     (nrst),
      .async_in ({serial_clock_pin, serial_data_in_pin}),
      .level    (pins_level)
   );

   assign sck_level = pins_level[1];
   assign sin_level = pins_level[0];
   assign sck_fall  = edge_seen(sck_prev, sck_level, 1'h0);
   assign sck_rise  = edge_seen(sck_prev, sck_level, 1'h1);

   // ==========================================================
   // Start decode; mode bit deliberately not looked at
   // Writes during a transfer are dropped so the byte in flight stays intact
   assign wr_ok = shift_write.valid && mode.port_enable_bit
                  && !mode.auto_transfer_enable_bit && !transfer_busy_flag;
   assign drive_bit = transfer_busy_flag && mode.port_enable_bit && sck_fall && !have_fall;
   assign sample    = transfer_busy_flag && have_fall && sck_rise && mode.port_enable_bit;
   assign last_rise = sample && (bit_cnt == csisb_pkg::LAST_BIT);

   // ==========================================================
   // Clock edge history
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sck_prev <= csisb_pkg::SCK_IDLE;
      end else begin
         sck_prev <= sck_level;
      end
   end

   // ==========================================================
   // Busy flag, bit count and fall seen
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transfer_busy_flag <= csisb_pkg::FLAG_RST;
         bit_cnt            <= csisb_pkg::BIT_CNT_RST;
         have_fall          <= csisb_pkg::FLAG_RST;
      end else if (wr_ok) begin
         transfer_busy_flag <= 1'h1;
         bit_cnt            <= csisb_pkg::BIT_CNT_RST;
         have_fall          <= 1'h0;
      end else if (!mode.port_enable_bit) begin
         // Disabling aborts silently, no interrupt
         transfer_busy_flag <= 1'h0;
         have_fall          <= 1'h0;
      end else if (transfer_busy_flag) begin
         if (sck_fall) begin
            have_fall <= 1'h1;
         end
         if (sample) begin
            bit_cnt   <= bit_cnt + 3'h1;
            have_fall <= 1'h0;
            if (last_rise) begin
               transfer_busy_flag <= 1'h0;
            end
         end
      end
   end

   // ==========================================================
   // Shift register and output pin
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         serial_shift_register <= csisb_pkg::SHIFT_RST;
         serial_data_out_pin   <= csisb_pkg::SDO_RST;
      end else if (wr_ok) begin
         serial_shift_register <= shift_write.data;
         serial_data_out_pin   <= 1'h0;
      end else if (transfer_busy_flag && mode.port_enable_bit) begin
         if (drive_bit) begin
            serial_data_out_pin <= serial_shift_register[7];
         end
         if (sample) begin
            // Old byte leaves at the top while new bits enter below
            serial_shift_register <= {serial_shift_register[6:0], sin_level};
         end
      end
   end

   // ==========================================================
   // Completion interrupt, one clock wide
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transfer_done_irq <= csisb_pkg::FLAG_RST;
      end else begin
         transfer_done_irq <= last_rise && !wr_ok;
      end
   end

   // ==========================================================
   // Checks: named steps of an exchange
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence seq_start;
      wr_ok;
   endsequence

   sequence seq_first_fall;
      drive_bit && !wr_ok;
   endsequence

   sequence seq_sample;
      sample && !wr_ok;
   endsequence

   sequence seq_last_sample;
      last_rise && !wr_ok;
   endsequence

   a_start_sets_busy: assert property (
      seq_start |=> transfer_busy_flag && bit_cnt == csisb_pkg::BIT_CNT_RST)
      else $error("write did not start exchange");
   a_write_low_out: assert property (
      seq_start |=> !serial_data_out_pin)
      else $error("data out not forced low on write");
   a_write_loads_byte: assert property (
      seq_start |=> serial_shift_register == $past(shift_write.data))
      else $error("written byte not loaded");
   a_busy_rise_cause: assert property (
      $rose(transfer_busy_flag) |-> $past(wr_ok))
      else $error("busy rose without accepted write");
   a_mode_bit_ignored: assert property (
      shift_write.valid && mode.port_enable_bit && mode.auto_transfer_mode_bit
      && !mode.auto_transfer_enable_bit && !transfer_busy_flag
      |=> transfer_busy_flag && serial_shift_register == $past(shift_write.data))
      else $error("start depended on mode bit");

   // ==========================================================
   // Checks: bit timing
   // A byte in flight may only move on serial clock edges
   a_fall_drives_msb: assert property (
      seq_first_fall |=> serial_data_out_pin == $past(serial_shift_register[7]))
      else $error("falling edge did not drive top bit");
   a_out_holds: assert property (
      !wr_ok && !drive_bit |=> $stable(serial_data_out_pin))
      else $error("data out moved without a fall");
   a_rise_samples_in: assert property (
      seq_sample |=> serial_shift_register[0] == $past(sin_level))
      else $error("rising edge did not sample input");
   a_shift_keeps_old: assert property (
      seq_sample |=> serial_shift_register[7:1] == $past(serial_shift_register[6:0]))
      else $error("old byte not shifted out");
   a_shift_holds: assert property (
      transfer_busy_flag && !sample |=> $stable(serial_shift_register))
      else $error("shift register moved without a rise");
   a_count_steps: assert property (
      seq_sample |=> bit_cnt == $past(bit_cnt) + 3'h1)
      else $error("bit count did not step on sample");

   // ==========================================================
   // Checks: completion
   // Abort by disable must stay silent
   a_done_with_idle: assert property (
      seq_last_sample |=> transfer_done_irq && !transfer_busy_flag)
      else $error("completion missing irq or busy");
   a_irq_one_pulse: assert property (
      transfer_done_irq |=> !transfer_done_irq)
      else $error("irq longer than one cycle");
   a_irq_has_cause: assert property (
      transfer_done_irq |-> $past(transfer_busy_flag) && $past(bit_cnt) == csisb_pkg::LAST_BIT)
      else $error("irq without eighth bit");
   a_busy_fall_cause: assert property (
      $fell(transfer_busy_flag) |-> $past(last_rise) || !$past(mode.port_enable_bit))
      else $error("busy fell before eighth bit");
   a_disable_aborts: assert property (
      !mode.port_enable_bit |=> !transfer_busy_flag && !transfer_done_irq)
      else $error("disable did not abort quietly");
   a_count_idle: assert property (
      !transfer_busy_flag && !wr_ok |=> $stable(bit_cnt))
      else $error("bit count moved while idle");
endmodule

`default_nettype wire

// file: test/csisb_peer.sv
/*
   Behavioural far-side peripheral that clocks one byte per go pulse.
   Assumes the block samples its pins through a slow synchroniser.
*/
`default_nettype none

module csisb_peer (
   input  wire logic       go,
   input  wire logic [7:0] tx,
   input  wire logic       sdo,
   output logic            sck,
   output logic            sin,
   output logic [7:0]      rx
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Frame engine, clock idles high between frames
   initial begin
      sck = 1'h1;
      sin = 1'h0;
      rx = 8'h00;
   end
   always @(posedge go) begin
      for (int i = 7; i >= 0; i--) begin
         sck = 1'h0;
         sin = tx[i];
         #40 sck = 1'h1;
         // Late capture: the block's output trails our falling edge
         #35 rx = {rx[6:0], sdo};
         #5;
      end
      // Released line must not keep the last bit
      sin = ~sin;
   end
endmodule

`default_nettype wire

// file: test/csisb_tb_top.sv
/*
   Self-checking bench for the single-byte serial exchange engine.
   Assumes the peer model in csisb_peer and the block's package.
*/
`default_nettype none

module csisb_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   clock;
   logic                   nrst;
   csisb_pkg::csisb_mode_t mode;
   csisb_pkg::csisb_wr_t   wr;
   logic                   sck, sin, sdo, busy, irq, go;
   logic [7:0]             shift, tx, rx;
   int                     err_total = 0;
   int                     cmp_count = 0;

   // ==========================================================
   // Clock and instances
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   csisb_top i_csisb_top (.clock(clock), .nrst(nrst), .mode(mode), .shift_write(wr),
      .serial_clock_pin(sck), .serial_data_in_pin(sin), .serial_data_out_pin(sdo),
      .serial_shift_register(shift), .transfer_busy_flag(busy), .transfer_done_irq(irq));
   csisb_peer i_csisb_peer (.go(go), .tx(tx), .sdo(sdo), .sck(sck), .sin(sin), .rx(rx));

   // ==========================================================
   // Tasks
   task automatic test_done;
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One write; ok says whether the block should accept it
   task automatic try(input logic [2:0] m, input logic [7:0] d, t, sh, input logic ok);
      logic [7:0] n;
      n = 8'h00;
      mode = m;
      @(posedge clock);
      #1 wr = {1'h1, d};
      tx = t;
      @(posedge clock);
      #1 wr.valid = 1'h0;
      go = ok;
      chk({7'h00, busy}, {7'h00, ok});
      if (ok) chk({7'h00, sdo}, 8'h00);
      // Fixed window covers a whole 80 ns-per-bit frame; a second write
      // lands mid-frame and must be dropped, so the byte in flight survives
      for (int k = 0; k < 100; k++) begin
         @(posedge clock);
         #1 n = n + {7'h00, irq};
         go = 1'h0;
         wr = {k == 20, ~d};
      end
      chk(n, {7'h00, ok});
      chk({7'h00, busy}, 8'h00);
      chk(shift, sh);
      if (ok) chk(rx, d);
   endtask

   // ==========================================================
   // Tests and watchdog
   initial begin
      nrst = 1'h0;
      mode = 3'h4;
      wr = '0;
      go = 1'h0;
      tx = 8'h00;
      repeat (6) @(posedge clock);
      #1 nrst = 1'h1;
      repeat (6) @(posedge clock);
      #1;
      try(3'h4, 8'hA5, 8'h3C, 8'h3C, 1'h1);
      try(3'h4, 8'h5A, 8'hC3, 8'hC3, 1'h1);
      try(3'h5, 8'hFF, 8'h96, 8'h96, 1'h1);
      try(3'h6, 8'h12, 8'h00, 8'h96, 1'h0);
      try(3'h1, 8'h34, 8'h00, 8'h96, 1'h0);
      test_done;
   end
   initial begin
      #20000;
      err_total++;
      test_done;
   end
endmodule

`default_nettype wire
